// ==== verilog/jtb_pkg.sv ====
// Shared constants and types of the boundary scan test port.
// Assumes one system clock; every count and code is used by name.
package jtb_pkg;

  // Instruction register
  localparam int IR_W = 16;
  localparam logic [15:0] IR_RESET = 16'h0004, IR_CAPTURE = 16'h0001;
  localparam logic [15:0] OP_EXTEST = 16'h0000, OP_SAMPLE = 16'h0002,
    OP_IDCODE = 16'h0004, OP_FMODE = 16'h0082, OP_FDATA = 16'h0083,
    OP_FADDR = 16'h0084, OP_FSCALE = 16'h0085, OP_BYPASS = 16'hFFFF;

  // Boundary chain layout
  localparam int BSR_LEN = 87;
  localparam int BIT_RST_EN = 0, BIT_RST_IO = 1, BIT_XTAL = 2;
  localparam int BIT_WEAK_PU = 3, BIT_ADDR_LO = 4, BIT_DATA_LO = 12;
  localparam int BIT_WR = 20, BIT_RD = 21, BIT_RMW = 22;
  localparam int BIT_PORT_BASE = 23, PORT_PINS = 32, SFR_W = 8;

  // Other data registers
  localparam int ID_W = 32, FMODE_W = 8, FDAT_W = 20;
  localparam int FADR_W = 16, FSCL_W = 8, FVAL_W = 18;
  localparam logic [1:0] FOP_READ = 2'h2, FOP_WRITE = 2'h3;

  // Reset values
  localparam logic [15:0] IR_SH_RESET = 16'h0000;
  localparam logic [7:0] FREG8_RESET = 8'h00;
  localparam logic [15:0] FADR_RESET = 16'h0000;

  typedef enum logic [15:0] {
    ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008, ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020,
    ST_PA_DR = 16'h0040, ST_EX2_DR = 16'h0080, ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000, ST_PA_IR = 16'h2000, ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } jtb_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic wr;
    logic rd;
    logic rmw;
  } jtb_sfr_t;

  typedef struct packed {
    logic [31:0] oe;
    logic [31:0] dout;
  } jtb_port_t;

endpackage : jtb_pkg

// ==== verilog/jtb_sync.sv ====
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes inputs change slowly against the system clock.
`timescale 1ns/100ps
`default_nettype none
module jtb_sync #(
  parameter int W = 1
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : jtb_sync
`default_nettype wire

// ==== verilog/jtb_tap_fsm.sv ====
// Sixteen-state test access port controller.
// Assumes a one-cycle strobe for each rising test clock edge.
`timescale 1ns/100ps
`default_nettype none
module jtb_tap_fsm
  import jtb_pkg::*;
(
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic tck_rise_in,
  input wire logic tms_in,
  output jtb_pkg::jtb_state_t state_out
);
  jtb_state_t state_nxt;

  // Standard next-state table, steered by the mode select
  always_comb begin
    case (state_out)
      ST_TLR: state_nxt = tms_in ? ST_TLR : ST_RTI;
      ST_RTI: state_nxt = tms_in ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: state_nxt = tms_in ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_nxt = tms_in ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_nxt = tms_in ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_nxt = tms_in ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: state_nxt = tms_in ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: state_nxt = tms_in ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_nxt = tms_in ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: state_nxt = tms_in ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: state_nxt = tms_in ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_nxt = tms_in ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_nxt = tms_in ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: state_nxt = tms_in ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: state_nxt = tms_in ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_nxt = tms_in ? ST_SEL_DR : ST_RTI;
      default: state_nxt = ST_TLR;
    endcase
  end

  // Advance only on a test clock rising edge
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      state_out <= ST_TLR;
    end else if (tck_rise_in) begin
      state_out <= state_nxt;
    end
  end
endmodule : jtb_tap_fsm
`default_nettype wire

// ==== verilog/jtb_tap_boundary_scan.sv ====
// Test access port with boundary chain and flash access registers.
// Assumes the test pins are asynchronous and the core runs on clock_in.
//
// Operation
// - Only four dedicated test pins: clock, mode select, data in, out.
// - A 16-bit instruction register selects one of seven data registers.
// - Three boundary-scan data registers plus four flash access registers.
// - Capture, shift and update follow the standard controller sequence.
// - Boundary chain is exactly 87 bits between data in and out.
// - External test captures and drives; sample captures but does not drive.
// - Sample/preload observes pins and presets latches, normal use intact.
// - Identification instruction selects the identification register.
// - Bypass instruction selects the bypass register.
// - Flash control instruction selects the flash mode register.
// - Flash data instruction selects the flash data register.
// - Flash address instruction selects the flash address register.
// - Flash scale instruction selects the flash prescale register.
// - Bit 0 is reset drive enable, bit 1 reset pin value.
// - Bit 2 captures the oscillator pin; its update is unused.
// - Bit 3 captures and drives the weak pull-up enable.
// - Bits 4 to 11 carry the register-bus address, LSB first.
// - Bits 12 to 19 capture read data, drive write data, LSB first.
// - Bits 20, 21, 22 carry write, read and read-modify-write strobes.
// - Port 0 uses bits 23 to 38: enable then data per pin.
// - Ports 1, 2, 3 repeat the pairing at 39, 55 and 71.
// - During external test every input to on-chip logic reads one.
// - The bypass register is one bit.
// - The identification register is 32 bits.
`timescale 1ns/100ps
`default_nettype none
module jtb_tap_boundary_scan #(
  // Arbitrary identification value; bit 0 stays one
  parameter logic [31:0] ID_CODE = 32'h0ACE_5001
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_en_out,
  input wire logic rst_pin_in,
  input wire logic xtal_pin_in,
  input wire logic [31:0] port_pin_in,
  input wire logic core_rst_en_in,
  input wire logic core_rst_o_in,
  input wire logic core_weak_pu_in,
  input wire jtb_pkg::jtb_sfr_t core_sfr_in,
  input wire logic [7:0] sfr_rdata_in,
  input wire jtb_pkg::jtb_port_t core_port_in,
  output logic rst_oe_out,
  output logic rst_o_out,
  output logic weak_pu_out,
  output jtb_pkg::jtb_sfr_t sfr_bus_out,
  output jtb_pkg::jtb_port_t port_out,
  output logic core_rst_pin_out,
  output logic core_xtal_out,
  output logic [31:0] core_port_pin_out,
  output logic [7:0] core_sfr_rdata_out,
  input wire logic flash_busy_in,
  input wire logic [17:0] flash_rdata_in,
  output logic [7:0] flash_mode_out,
  output logic [15:0] flash_addr_out,
  output logic [7:0] flash_scale_out,
  output logic [17:0] flash_wdata_out,
  output logic flash_wr_out,
  output logic flash_rd_out
);
  import jtb_pkg::*;

  logic [2:0] tap_s;
  logic [33:0] pin_s;
  logic tck_prev_r;
  jtb_state_t tap_state;
  logic [IR_W-1:0] ir_r;
  logic [IR_W-1:0] ir_sh_r;
  logic [BSR_LEN-1:0] bsr_sh_r;
  logic [BSR_LEN-1:0] bsr_upd_r;
  logic [ID_W-1:0] id_sh_r;
  logic byp_r;
  logic [FMODE_W-1:0] fmode_sh_r;
  logic [FDAT_W-1:0] fdat_sh_r;
  logic [FADR_W-1:0] fadr_sh_r;
  logic [FSCL_W-1:0] fscl_sh_r;
  logic tdo_r;
  logic tdo_en_r;

  // Test pins and device pins are asynchronous; two flops each
  jtb_sync #(.W(3)) u_tap_sync (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .async_in({tck_in, tms_in, tdi_in}),
    .sync_out(tap_s)
  );
  jtb_sync #(.W(34)) u_pin_sync (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .async_in({rst_pin_in, xtal_pin_in, port_pin_in}),
    .sync_out(pin_s)
  );

  // Test clock edge detection on the synchronised level
  wire tck_s = tap_s[2];
  wire tms_s = tap_s[1];
  wire tdi_s = tap_s[0];
  wire tck_rise = tck_s & ~tck_prev_r;
  wire tck_fall = ~tck_s & tck_prev_r;
  wire rst_pin_s = pin_s[33];
  wire xtal_s = pin_s[32];
  wire [31:0] port_pin_s = pin_s[31:0];

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      tck_prev_r <= 1'b0;
    end else begin
      tck_prev_r <= tck_s;
    end
  end

  jtb_tap_fsm u_fsm (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .tck_rise_in(tck_rise),
    .tms_in(tms_s),
    .state_out(tap_state)
  );

  // Action strobes, one system cycle per test clock rising edge
  wire in_tlr = (tap_state == ST_TLR);
  wire cap_dr = tck_rise & (tap_state == ST_CAP_DR);
  wire sh_dr = tck_rise & (tap_state == ST_SH_DR);
  wire upd_dr = tck_rise & (tap_state == ST_UPD_DR);
  wire cap_ir = tck_rise & (tap_state == ST_CAP_IR);
  wire sh_ir = tck_rise & (tap_state == ST_SH_IR);
  wire upd_ir = tck_rise & (tap_state == ST_UPD_IR);
  wire shifting = (tap_state == ST_SH_DR) | (tap_state == ST_SH_IR);

  // Instruction decode
  wire extest = (ir_r == OP_EXTEST);
  wire sel_bsr = extest | (ir_r == OP_SAMPLE);
  wire sel_id = (ir_r == OP_IDCODE);
  wire sel_fmode = (ir_r == OP_FMODE);
  wire sel_fdat = (ir_r == OP_FDATA);
  wire sel_fadr = (ir_r == OP_FADDR);
  wire sel_fscl = (ir_r == OP_FSCALE);
  // Explicit bypass code and every unknown code land here
  wire sel_byp = ~(sel_bsr | sel_id | sel_fmode | sel_fdat | sel_fadr |
                   sel_fscl);

  // Instruction shift stage and active instruction
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      ir_sh_r <= IR_SH_RESET;
      ir_r <= IR_RESET;
    end else begin
      if (cap_ir) begin
        ir_sh_r <= IR_CAPTURE;
      end else if (sh_ir) begin
        ir_sh_r <= {tdi_s, ir_sh_r[IR_W-1:1]};
      end
      if (in_tlr) begin
        ir_r <= IR_RESET;
      end else if (upd_ir) begin
        ir_r <= ir_sh_r;
      end
    end
  end

  // Boundary capture vector built from core and synchronised pins
  logic [BSR_LEN-1:0] bsr_cap;
  assign bsr_cap[BIT_RST_EN] = core_rst_en_in;
  assign bsr_cap[BIT_RST_IO] = rst_pin_s;
  assign bsr_cap[BIT_XTAL] = xtal_s;
  assign bsr_cap[BIT_WEAK_PU] = core_weak_pu_in;
  assign bsr_cap[BIT_ADDR_LO +: SFR_W] = core_sfr_in.addr;
  assign bsr_cap[BIT_DATA_LO +: SFR_W] = sfr_rdata_in;
  assign bsr_cap[BIT_WR] = core_sfr_in.wr;
  assign bsr_cap[BIT_RD] = core_sfr_in.rd;
  assign bsr_cap[BIT_RMW] = core_sfr_in.rmw;

  // Per-pin enable and data pairs, ports in order 0 to 3
  logic [31:0] upd_oe;
  logic [31:0] upd_do;
  genvar k;
  generate
    for (k = 0; k < PORT_PINS; k++) begin : g_pin
      assign bsr_cap[BIT_PORT_BASE + 2*k] = core_port_in.oe[k];
      assign bsr_cap[BIT_PORT_BASE + 2*k + 1] = port_pin_s[k];
      assign upd_oe[k] = bsr_upd_r[BIT_PORT_BASE + 2*k];
      assign upd_do[k] = bsr_upd_r[BIT_PORT_BASE + 2*k + 1];
    end
  endgenerate

  // Boundary shift stage and update latches
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      bsr_sh_r <= '0;
      bsr_upd_r <= '0;
    end else begin
      if (cap_dr & sel_bsr) begin
        bsr_sh_r <= bsr_cap;
      end else if (sh_dr & sel_bsr) begin
        bsr_sh_r <= {tdi_s, bsr_sh_r[BSR_LEN-1:1]};
      end
      // Preload also lands here; only external test drives it out
      if (upd_dr & sel_bsr) begin
        bsr_upd_r <= bsr_sh_r;
      end
    end
  end

  // Identification and bypass registers
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      id_sh_r <= '0;
      byp_r <= 1'b0;
    end else begin
      if (cap_dr & sel_id) begin
        id_sh_r <= ID_CODE;
      end else if (sh_dr & sel_id) begin
        id_sh_r <= {tdi_s, id_sh_r[ID_W-1:1]};
      end
      if (cap_dr & sel_byp) begin
        byp_r <= 1'b0;
      end else if (sh_dr & sel_byp) begin
        byp_r <= tdi_s;
      end
    end
  end

  // Flash mode, address and prescale: shift in, apply on update
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      fmode_sh_r <= FREG8_RESET;
      fadr_sh_r <= FADR_RESET;
      fscl_sh_r <= FREG8_RESET;
      flash_mode_out <= FREG8_RESET;
      flash_addr_out <= FADR_RESET;
      flash_scale_out <= FREG8_RESET;
    end else begin
      if (cap_dr & sel_fmode) begin
        fmode_sh_r <= flash_mode_out;
      end else if (sh_dr & sel_fmode) begin
        fmode_sh_r <= {tdi_s, fmode_sh_r[FMODE_W-1:1]};
      end
      if (cap_dr & sel_fadr) begin
        fadr_sh_r <= flash_addr_out;
      end else if (sh_dr & sel_fadr) begin
        fadr_sh_r <= {tdi_s, fadr_sh_r[FADR_W-1:1]};
      end
      if (cap_dr & sel_fscl) begin
        fscl_sh_r <= flash_scale_out;
      end else if (sh_dr & sel_fscl) begin
        fscl_sh_r <= {tdi_s, fscl_sh_r[FSCL_W-1:1]};
      end
      if (upd_dr & sel_fmode) begin
        flash_mode_out <= fmode_sh_r;
      end
      if (upd_dr & sel_fadr) begin
        flash_addr_out <= fadr_sh_r;
      end
      if (upd_dr & sel_fscl) begin
        flash_scale_out <= fscl_sh_r;
      end
    end
  end

  // Flash data command decode; busy blocks new reads and writes
  wire [1:0] fdat_op = fdat_sh_r[FDAT_W-1 -: 2];
  wire fdat_go = upd_dr & sel_fdat & ~flash_busy_in;
  wire fdat_wr = fdat_go & (fdat_op == FOP_WRITE);
  wire fdat_rd = fdat_go & (fdat_op == FOP_READ);

  // Flash data register: status out, command in, one-cycle strobes
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      fdat_sh_r <= '0;
      flash_wdata_out <= '0;
      flash_wr_out <= 1'b0;
      flash_rd_out <= 1'b0;
    end else begin
      if (cap_dr & sel_fdat) begin
        fdat_sh_r <= {1'b0, flash_rdata_in, flash_busy_in};
      end else if (sh_dr & sel_fdat) begin
        fdat_sh_r <= {tdi_s, fdat_sh_r[FDAT_W-1:1]};
      end
      if (fdat_wr) begin
        flash_wdata_out <= fdat_sh_r[FVAL_W-1:0];
      end
      flash_wr_out <= fdat_wr;
      flash_rd_out <= fdat_rd;
    end
  end

  // Serial output select for the register in the shift path
  wire tdo_dr = sel_bsr ? bsr_sh_r[0] :
                sel_id ? id_sh_r[0] :
                sel_fmode ? fmode_sh_r[0] :
                sel_fdat ? fdat_sh_r[0] :
                sel_fadr ? fadr_sh_r[0] :
                sel_fscl ? fscl_sh_r[0] : byp_r;
  wire tdo_bit = (tap_state == ST_SH_IR) ? ir_sh_r[0] : tdo_dr;

  // Output changes on the falling test clock edge so the far end can sample
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      tdo_r <= 1'b0;
      tdo_en_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_r <= tdo_bit;
      tdo_en_r <= shifting;
    end
  end
  assign tdo_out = tdo_r;
  assign tdo_en_out = tdo_en_r;

  // Pin-side values: update latches under external test, core otherwise
  wire rst_oe_nxt = extest ? bsr_upd_r[BIT_RST_EN] : core_rst_en_in;
  wire rst_o_nxt = extest ? bsr_upd_r[BIT_RST_IO] : core_rst_o_in;
  wire weak_pu_nxt = extest ? bsr_upd_r[BIT_WEAK_PU] : core_weak_pu_in;
  jtb_sfr_t sfr_nxt;
  jtb_port_t port_nxt;
  assign sfr_nxt.addr = extest ? bsr_upd_r[BIT_ADDR_LO +: SFR_W] :
                        core_sfr_in.addr;
  assign sfr_nxt.data = extest ? bsr_upd_r[BIT_DATA_LO +: SFR_W] :
                        core_sfr_in.data;
  assign sfr_nxt.wr = extest ? bsr_upd_r[BIT_WR] : core_sfr_in.wr;
  assign sfr_nxt.rd = extest ? bsr_upd_r[BIT_RD] : core_sfr_in.rd;
  assign sfr_nxt.rmw = extest ? bsr_upd_r[BIT_RMW] : core_sfr_in.rmw;
  assign port_nxt.oe = extest ? upd_oe : core_port_in.oe;
  assign port_nxt.dout = extest ? upd_do : core_port_in.dout;

  // Registered pin side; one extra cycle of latency in normal use
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      rst_oe_out <= 1'b0;
      rst_o_out <= 1'b0;
      weak_pu_out <= 1'b0;
      sfr_bus_out <= '0;
      port_out <= '0;
    end else begin
      rst_oe_out <= rst_oe_nxt;
      rst_o_out <= rst_o_nxt;
      weak_pu_out <= weak_pu_nxt;
      sfr_bus_out <= sfr_nxt;
      port_out <= port_nxt;
    end
  end

  // Core-side inputs, held high while pins are under test control
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      core_rst_pin_out <= 1'b1;
      core_xtal_out <= 1'b1;
      core_port_pin_out <= '1;
      core_sfr_rdata_out <= '1;
    end else begin
      core_rst_pin_out <= extest | rst_pin_s;
      core_xtal_out <= extest | xtal_s;
      core_port_pin_out <= extest ? '1 : port_pin_s;
      core_sfr_rdata_out <= extest ? '1 : sfr_rdata_in;
    end
  end
endmodule : jtb_tap_boundary_scan
`default_nettype wire

// ==== test/jtb_ctrl_model.sv ====
// Behavioural external test controller driving the four-wire port.
// Assumes the system clock paces it; one test clock is ten cycles.
`timescale 1ns/100ps
`default_nettype none
module jtb_ctrl_model (
  input wire logic clock_in,
  input wire logic tdo_in,
  output logic tck_out = 1'b0, // Parks low between frames
  output logic tms_out = 1'b1,
  output logic tdi_out = 1'b0,
  output logic rx_valid_out = 1'b0,
  output logic [86:0] rx_data_out = '0
);
  // One test clock; output read late in the low half, well settled
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge clock_in);
    tms_out <= tms;
    tdi_out <= tdi;
    repeat (4) @(posedge clock_in);
    tdo = tdo_in;
    tck_out <= 1'b1;
    repeat (5) @(posedge clock_in);
    tck_out <= 1'b0;
  endtask : step

  // Five high mode bits reach reset from any state, then idle
  task automatic reset_tap();
    logic b;
    repeat (5) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask : reset_tap

  // From idle: shift n bits LSB first, update, back to idle
  task automatic scan(input logic ir, input logic [86:0] din, input int n);
    logic [86:0] q;
    logic b;
    q = '0;
    step(1'b1, 1'b0, b);
    if (ir) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      q[i] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    rx_data_out <= q;
    rx_valid_out <= 1'b1;
    @(posedge clock_in);
    rx_valid_out <= 1'b0;
  endtask : scan
endmodule : jtb_ctrl_model
`default_nettype wire

// ==== test/jtb_tap_props.sv ====
// Port-level properties of the boundary scan test port.
// Assumes binding to the top module and one system clock domain.
`timescale 1ns/100ps
`default_nettype none
module jtb_tap_props
  import jtb_pkg::*;
(
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic tck_in,
  input wire logic tdo_out,
  input wire logic tdo_en_out,
  input wire logic [7:0] sfr_rdata_in,
  input wire logic [7:0] core_sfr_rdata_out,
  input wire jtb_pkg::jtb_port_t core_port_in,
  input wire jtb_pkg::jtb_port_t port_out,
  input wire logic [31:0] core_port_pin_out,
  input wire logic flash_busy_in,
  input wire logic flash_wr_out,
  input wire logic flash_rd_out,
  input wire logic [17:0] flash_wdata_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  // Serial side moves only in the low half of the test clock
  a_tdo_low_half: assert property (
    $changed(tdo_out) |-> !tck_in) else $error("tdo moved with tck high");
  a_tdo_en_low: assert property (
    $changed(tdo_en_out) |-> !tck_in) else $error("tdo_en moved, tck high");
  // Flash strobes are single pulses; writes respect busy
  a_wr_one_clk: assert property (
    flash_wr_out |=> !flash_wr_out) else $error("write pulse too long");
  a_rd_one_clk: assert property (
    flash_rd_out |=> !flash_rd_out ##1 !flash_wr_out)
    else $error("read pulse too long or write follows");
  a_busy_blocks_wr: assert property (
    flash_wr_out |-> !$past(flash_busy_in)) else $error("write while busy");
  a_wdata_on_write: assert property (
    $changed(flash_wdata_out) |-> flash_wr_out)
    else $error("write data moved without write");
  // Core side is either forced to ones or the bus value one clock late
  a_rdata_path: assert property (
    core_sfr_rdata_out != 8'hFF |-> core_sfr_rdata_out == $past(sfr_rdata_in))
    else $error("core read data neither forced nor passed");
  // Pins leave the core value only while core inputs are forced
  a_pins_owned: assert property (
    port_out != $past(core_port_in) |-> core_port_pin_out == 32'hFFFF_FFFF)
    else $error("pins diverted outside external test");

  c_write: cover property (flash_wr_out);
  c_read: cover property (flash_rd_out);
  c_extest: cover property (port_out != $past(core_port_in));
endmodule : jtb_tap_props
`default_nettype wire

bind jtb_tap_boundary_scan jtb_tap_props jtb_tap_props_i (
  .clock_in, .resetn_in, .tck_in, .tdo_out, .tdo_en_out, .sfr_rdata_in,
  .core_sfr_rdata_out, .core_port_in, .port_out, .core_port_pin_out,
  .flash_busy_in, .flash_wr_out, .flash_rd_out, .flash_wdata_out);

// ==== test/testbench.sv ====
// Self-checking bench of the boundary scan test port.
// Assumes the controller model and checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import jtb_pkg::*;
  // Arbitrary identification value, bit 0 kept set
  localparam logic [31:0] TB_ID = 32'h1357_9BDF;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic tck_in, tms_in, tdi_in, tdo_out, tdo_en_out, rx_valid;
  logic rst_pin_in = 1'b0, xtal_pin_in = 1'b0, flash_busy_in = 1'b0;
  logic core_rst_en_in = 1'b0, core_rst_o_in = 1'b0, core_weak_pu_in = 1'b0;
  logic [31:0] port_pin_in = '0, core_port_pin_out;
  logic [7:0] sfr_rdata_in = '0, core_sfr_rdata_out, flash_mode_out;
  logic [17:0] flash_rdata_in = '0, flash_wdata_out, wd, ew;
  jtb_sfr_t core_sfr_in = '0, sfr_bus_out;
  jtb_port_t core_port_in = '0, port_out;
  logic rst_oe_out, rst_o_out, weak_pu_out, core_rst_pin_out, core_xtal_out;
  logic [7:0] flash_scale_out;
  logic [15:0] flash_addr_out, op;
  logic flash_wr_out, flash_rd_out, tb_valid = 1'b0;
  logic [86:0] rx_data, tb_val = '0, d, x, m_exp, m_got;
  logic [86:0] eq[$];
  string nq[$], m_nm;
  int err_count = 0, checks = 0, seed = 2, wr_cnt = 0, rd_cnt = 0;
  int wr0, rd0, n;

  always #4 clock_in = ~clock_in;

  jtb_tap_boundary_scan #(.ID_CODE(TB_ID)) jtb_tap_boundary_scan_i (
    .clock_in, .resetn_in, .tck_in, .tms_in, .tdi_in, .tdo_out, .tdo_en_out,
    .rst_pin_in, .xtal_pin_in, .port_pin_in, .core_rst_en_in, .core_rst_o_in,
    .core_weak_pu_in, .core_sfr_in, .sfr_rdata_in, .core_port_in, .rst_oe_out,
    .rst_o_out, .weak_pu_out, .sfr_bus_out, .port_out, .core_rst_pin_out,
    .core_xtal_out, .core_port_pin_out, .core_sfr_rdata_out, .flash_busy_in,
    .flash_rdata_in, .flash_mode_out, .flash_addr_out, .flash_scale_out,
    .flash_wdata_out, .flash_wr_out, .flash_rd_out);
  jtb_ctrl_model jtb_ctrl_model_i (.clock_in, .tdo_in(tdo_out),
    .tck_out(tck_in), .tms_out(tms_in), .tdi_out(tdi_in),
    .rx_valid_out(rx_valid), .rx_data_out(rx_data));

  // Pulse counters; results compared against the oldest note
  always @(posedge clock_in) begin
    if (flash_wr_out === 1'b1) wr_cnt++;
    if (flash_rd_out === 1'b1) rd_cnt++;
    if (rx_valid === 1'b1 || tb_valid) begin
      m_got = tb_valid ? tb_val : rx_data;
      m_nm = eq.size() > 0 ? nq.pop_front() : "no note";
      m_exp = eq.size() > 0 ? eq.pop_front() : 'x;
      checks++;
      if (m_got !== m_exp) begin
        err_count++;
        $display("MISMATCH %s expected %h seen %h", m_nm, m_exp, m_got);
      end
    end
  end

  task automatic expect_v(input string nm, input logic [86:0] v);
    nq.push_back(nm);
    eq.push_back(v);
  endtask : expect_v

  // Port values travel through the same comparing process
  task automatic chk(input string nm, input logic [86:0] e, input logic [86:0] g);
    expect_v(nm, e);
    tb_val <= g;
    tb_valid <= 1'b1;
    @(posedge clock_in);
    tb_valid <= 1'b0;
    @(posedge clock_in);
  endtask : chk

  task automatic load_ir(input logic [15:0] v);
    expect_v("ir capture", 87'(IR_CAPTURE));
    jtb_ctrl_model_i.scan(1'b1, 87'(v), IR_W);
  endtask : load_ir

  // Chain image: reset, oscillator, pull-up and sfr in bits 0-22, then enable/data pairs per pin
  function automatic logic [86:0] vec(input jtb_sfr_t s, input logic wk,
      input logic xt, input logic ro, input logic oe, input logic [31:0] po,
      input logic [31:0] pv);
    logic [86:0] v;
    v[22:0] = {s.rmw, s.rd, s.wr, s.data, s.addr, wk, xt, ro, oe};
    for (int k = 0; k < 32; k++) v[23 + 2 * k +: 2] = {pv[k], po[k]};
    return v;
  endfunction : vec

  function automatic logic [86:0] cap_vec();
    return vec({core_sfr_in.addr, sfr_rdata_in, core_sfr_in.wr,
      core_sfr_in.rd, core_sfr_in.rmw}, core_weak_pu_in, xtal_pin_in,
      rst_pin_in, core_rst_en_in, core_port_in.oe, port_pin_in);
  endfunction : cap_vec

  function automatic logic [86:0] pin_vec();
    return vec(sfr_bus_out, weak_pu_out, 1'b0, rst_o_out, rst_oe_out,
      port_out.oe, port_out.dout);
  endfunction : pin_vec

  task automatic rnd_in();
    @(posedge clock_in);
    {rst_pin_in, xtal_pin_in, core_rst_en_in} <= 3'($random(seed));
    {core_rst_o_in, core_weak_pu_in} <= 2'($random(seed));
    port_pin_in <= $random(seed);
    core_sfr_in <= 19'($random(seed));
    sfr_rdata_in <= 8'($random(seed));
    core_port_in <= {$random(seed), $random(seed)};
    flash_rdata_in <= 18'($random(seed));
    repeat (6) @(posedge clock_in);
  endtask : rnd_in

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (6) @(posedge clock_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    jtb_ctrl_model_i.reset_tap();
    expect_v("idcode", 87'(TB_ID));
    jtb_ctrl_model_i.scan(1'b0, '1, ID_W);
    // Bypass and an undefined code both give a one-bit path
    for (int k = 0; k < 2; k++) begin
      load_ir(k == 0 ? OP_BYPASS : {4'h1, 12'($random(seed))});
      d = 87'($random(seed));
      expect_v("bypass", 87'({d[0], 1'b0}));
      jtb_ctrl_model_i.scan(1'b0, d, 2);
    end
    $display("bypass test done");
    // Sample preloads latches; external test then drives them
    rnd_in();
    load_ir(OP_SAMPLE);
    d = 87'({$random(seed), $random(seed), $random(seed)});
    expect_v("sample capture", cap_vec());
    jtb_ctrl_model_i.scan(1'b0, d, BSR_LEN);
    load_ir(OP_EXTEST);
    x = {d[86:3], 1'b0, d[1:0]};
    chk("extest pins", x, pin_vec());
    x = 87'({core_rst_pin_out, core_xtal_out, core_port_pin_out,
      core_sfr_rdata_out});
    chk("core forced", 87'({42{1'b1}}), x);
    rnd_in();
    d = 87'({$random(seed), $random(seed), $random(seed)});
    expect_v("extest capture", cap_vec());
    jtb_ctrl_model_i.scan(1'b0, d, BSR_LEN);
    chk("extest update", {d[86:3], 1'b0, d[1:0]}, pin_vec());
    // Leaving external test hands pins back to the core
    load_ir(OP_SAMPLE);
    x = vec(core_sfr_in, core_weak_pu_in, 1'b0, core_rst_o_in,
      core_rst_en_in, core_port_in.oe, core_port_in.dout);
    chk("pass pins", x, pin_vec());
    $display("boundary test done");
    // Mode, address and prescale: reset value by capture, then update
    for (int k = 0; k < 3; k++) begin
      op = k == 0 ? OP_FMODE : k == 1 ? OP_FADDR : OP_FSCALE;
      n = k == 1 ? FADR_W : FMODE_W;
      load_ir(op);
      d = 87'($random(seed)) & ((87'(1) << n) - 87'(1));
      expect_v("flash reg reset", '0);
      jtb_ctrl_model_i.scan(1'b0, d, n);
      x = 87'(k == 0 ? flash_mode_out : k == 1 ? flash_addr_out :
        flash_scale_out);
      chk("flash reg out", d, x);
    end
    // Flash data: write, read, write while busy, poll
    load_ir(OP_FDATA);
    ew = '0;
    for (int k = 0; k < 4; k++) begin
      @(posedge clock_in);
      flash_busy_in <= k == 2;
      wd <= 18'($random(seed));
      repeat (2) @(posedge clock_in);
      wr0 = wr_cnt;
      rd0 = rd_cnt;
      if (k == 0) ew = wd;
      expect_v("flash capture", 87'({1'b0, flash_rdata_in, flash_busy_in}));
      d = 87'({k == 1 ? 2'b10 : k == 3 ? 2'b01 : 2'b11, wd});
      jtb_ctrl_model_i.scan(1'b0, d, FDAT_W);
      x = 87'({8'(wr_cnt - wr0), 8'(rd_cnt - rd0), flash_wdata_out});
      chk("flash ops", 87'({8'(k == 0), 8'(k == 1), ew}), x);
    end
    $display("flash test done");
    give_verdict();
  end

  // About eight times the expected run length
  initial begin
    #400000;
    err_count++;
    $display("MISMATCH run time expected end seen timeout");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
